// *** hw/vmc_config_bank.sv ***
// Global master-access, self-test and error-interrupt configuration bank.
// Assumes a byte-wide register port and one board clock; the firmware
// reports its own events and statuses as synchronous pulses and levels.
`include "vmc_cfg.svh"

////////////////////////////////////////////////////////////////////////////////

// Notes on behaviour
// - Bits 7-6 of size byte pick width: 00 word, 10 half, 01 byte.
// - Low six bits of size byte drive the address modifier lines directly.
// - Reset loads the size byte with 16-bit, A24 nonprivileged data.
// - Self-test start runs only the tests whose select bits are set.
// - Select bits 5..0: DMA read, DMA write, fault, UART, timer, interrupt.
// - Settled-enable raises the global interrupt when firmware finishes a write.
// - Mask bit 6 lets reserved-nonzero status raise the error interrupt.
// - Mask bit 5 lets self-test-failed status raise the error interrupt.
// - Mask bit 4 lets hardware-fault status raise the error interrupt.
// - Mask bit 3 lets a master bus fault raise the error interrupt.
// - Interrupt level comes from mask bits 2-0; level zero disables it.
// - Master buffer accesses are base-relative with the size byte settings.
// - A24 master accesses ignore the top byte of the buffer base.
// - Slave mode decodes the base in A24 or A32 per wide decode bit.
// - Any master operation ending in a bus fault sets the bus-fault status.
// - Any nonzero reserved register bit sets the reserved-nonzero status.
module vmc_config_bank #(
	parameter int ALIGN_BITS = 18
) (
	input  wire logic        clk_in,
	input  wire logic        rst_b_in,
	// Register port.
	input  wire logic [7:0]  reg_addr_in,
	input  wire logic        reg_wr_in,
	input  wire logic        reg_rd_in,
	input  wire logic [7:0]  reg_wdata_in,
	output logic      [7:0]  reg_rdata_out,
	output logic             reg_ack_out,
	// Control and status from the rest of the board.
	input  wire logic        self_test_start_bit_in,
	input  wire logic        slave_wide_decode_in,
	input  wire logic        reg_settled_in,
	input  wire logic        selftest_fail_flag_in,
	input  wire logic        hw_fault_flag_in,
	input  wire logic        master_bus_error_in,
	input  wire logic        bus_fault_clear_in,
	input  wire logic        reserved_other_in,
	// Interrupt acknowledge.
	input  wire logic        iack_in,
	input  wire logic [2:0]  iack_level_in,
	output logic             iack_ack_out,
	output logic      [7:0]  iack_vector_out,
	output logic      [7:1]  irq_request_out,
	// Master side.
	input  wire logic        master_req_in,
	input  wire logic [31:0] master_offset_in,
	output logic             master_start_out,
	output logic      [31:0] master_addr_out,
	output logic      [5:0]  master_modifier_field_out,
	output vmc_pkg::vmc_width_t master_width_code_out,
	// Slave side.
	input  wire logic        slave_valid_in,
	input  wire logic [31:0] slave_addr_in,
	input  wire logic [5:0]  slave_am_in,
	output logic             slave_hit_out,
	output logic      [31:0] slave_offset_out,
	// Self-test launch and status.
	output logic      [5:0]  self_test_run_out,
	output logic             bus_fault_flag_out,
	output logic             reserved_nonzero_flag_out,
	output logic             any_error_out
);

	logic [7:0]  master_size_modifier;
	logic [7:0]  self_test_select;
	logic [7:0]  error_interrupt_control;
	logic [7:0]  error_interrupt_vector;
	logic [31:0] user_buffer_base;

	logic        hit_size;
	logic        hit_test;
	logic        hit_ctrl;
	logic        hit_vec;
	logic [3:0]  hit_base;
	logic [1:0]  flag_set;
	logic [1:0]  flag_clear;
	logic [1:0]  flags;
	logic        reg_pending_flag;
	logic        reserved_local;
	logic        error_pending;
	logic        irq_pending;
	logic [2:0]  error_irq_level;
	logic        iack_match;
	logic [7:0]  next_rdata;
	logic [7:1]  next_request;

	////////////////////////////////////////////////////////////////////////
	// Address decode.

	assign hit_size = (reg_addr_in == `VMC_OFS_SIZE_MOD);
	assign hit_test = (reg_addr_in == `VMC_OFS_TEST_SEL);
	assign hit_ctrl = (reg_addr_in == `VMC_OFS_ERR_CTRL);
	assign hit_vec  = (reg_addr_in == `VMC_OFS_ERR_VEC);
	assign hit_base = {reg_addr_in == `VMC_OFS_BASE_B3,
		reg_addr_in == `VMC_OFS_BASE_B2,
		reg_addr_in == `VMC_OFS_BASE_B1,
		reg_addr_in == `VMC_OFS_BASE_B0};

	////////////////////////////////////////////////////////////////////////
	// Register file.

	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			master_size_modifier <= `VMC_RST_SIZE_MOD;
		end
		else if (reg_wr_in && hit_size)
		begin
			master_size_modifier <= reg_wdata_in;
		end
	end

	// The reserved top bits are stored as written so software sees them.
	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			self_test_select <= `VMC_RST_TEST_SEL;
		end
		else if (reg_wr_in && hit_test)
		begin
			self_test_select <= reg_wdata_in;
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			error_interrupt_control <= `VMC_RST_ERR_CTRL;
		end
		else if (reg_wr_in && hit_ctrl)
		begin
			error_interrupt_control <= reg_wdata_in;
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			error_interrupt_vector <= `VMC_RST_ERR_VEC;
		end
		else if (reg_wr_in && hit_vec)
		begin
			error_interrupt_vector <= reg_wdata_in;
		end
	end

	// The longword base is written a byte at a time, high byte lowest.
	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			user_buffer_base <= `VMC_RST_BASE;
		end
		else if (reg_wr_in)
		begin
			for (int i = 0; i < 4; i++)
			begin
				if (hit_base[i])
					user_buffer_base[8*i +: 8] <= reg_wdata_in;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read path; unmapped addresses answer with zero.

	always_comb
	begin
		next_rdata = `VMC_UNMAPPED_DATA;
		if (hit_size)
			next_rdata = master_size_modifier;
		else if (hit_test)
			next_rdata = self_test_select;
		else if (hit_ctrl)
			next_rdata = error_interrupt_control;
		else if (hit_vec)
			next_rdata = error_interrupt_vector;
		else
		begin
			for (int i = 0; i < 4; i++)
			begin
				if (hit_base[i])
					next_rdata = user_buffer_base[8*i +: 8];
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			reg_rdata_out <= 8'h00;
			reg_ack_out   <= 1'b0;
		end
		else
		begin
			reg_ack_out <= reg_wr_in | reg_rd_in;
			if (reg_rd_in)
				reg_rdata_out <= next_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Master cycle attributes.

	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			master_width_code_out <= vmc_pkg::VMC_WIDTH_HALF;
		end
		else
		begin
			unique case (master_size_modifier[`VMC_FLD_WIDTH_HI:
				`VMC_FLD_WIDTH_LO])
			`VMC_CODE_WORD: master_width_code_out <= vmc_pkg::VMC_WIDTH_WORD;
			`VMC_CODE_HALF: master_width_code_out <= vmc_pkg::VMC_WIDTH_HALF;
			`VMC_CODE_BYTE: master_width_code_out <= vmc_pkg::VMC_WIDTH_BYTE;
			default:        master_width_code_out <= vmc_pkg::VMC_WIDTH_UNDEF;
			endcase
		end
	end

	// The modifier is copied bit for bit; no legality check is made here.
	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			master_modifier_field_out <= 6'h39;
		end
		else
		begin
			master_modifier_field_out <=
				master_size_modifier[`VMC_FLD_AM_HI:0];
		end
	end

	vmc_addr_unit #(
		.ALIGN_BITS (ALIGN_BITS)
	) u_addr (
		.clk_in           (clk_in),
		.rst_b_in         (rst_b_in),
		.base_in          (user_buffer_base),
		.master_am_in     (master_size_modifier[`VMC_FLD_AM_HI:0]),
		.master_req_in    (master_req_in),
		.master_offset_in (master_offset_in),
		.wide_decode_in   (slave_wide_decode_in),
		.slave_valid_in   (slave_valid_in),
		.slave_addr_in    (slave_addr_in),
		.slave_am_in      (slave_am_in),
		.master_start_out (master_start_out),
		.master_addr_out  (master_addr_out),
		.slave_hit_out    (slave_hit_out),
		.slave_offset_out (slave_offset_out)
	);

	////////////////////////////////////////////////////////////////////////
	// Self-test launch.

	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			self_test_run_out <= 6'h00;
		end
		else if (self_test_start_bit_in)
		begin
			self_test_run_out <= self_test_select[`VMC_FLD_TEST_HI:0];
		end
		else
		begin
			self_test_run_out <= 6'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Status flags.

	assign reserved_local = |self_test_select[`VMC_FLD_TEST_RSV_HI:
		`VMC_FLD_TEST_RSV_LO];

	// Bit 0 is the bus fault, bit 1 the firmware settled event.
	assign flag_set = {reg_settled_in
		&& error_interrupt_control[`VMC_FLD_SETTLED_EN],
		master_bus_error_in};
	assign flag_clear = {iack_match, bus_fault_clear_in};

	vmc_sticky_flag #(
		.WIDTH (2)
	) u_flags (
		.clk_in   (clk_in),
		.rst_b_in (rst_b_in),
		.set_in   (flag_set),
		.clear_in (flag_clear),
		.flag_out (flags)
	);

	assign reg_pending_flag = flags[1];

	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			bus_fault_flag_out        <= 1'b0;
			reserved_nonzero_flag_out <= 1'b0;
			any_error_out             <= 1'b0;
		end
		else
		begin
			bus_fault_flag_out        <= flags[0];
			reserved_nonzero_flag_out <= reserved_local
				| reserved_other_in;
			any_error_out <= flags[0] | reserved_local | reserved_other_in
				| selftest_fail_flag_in | hw_fault_flag_in;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupt request and acknowledge.

	assign error_pending =
		(error_interrupt_control[`VMC_FLD_RSV_EN]
		&& reserved_nonzero_flag_out)
		|| (error_interrupt_control[`VMC_FLD_SELFTEST_FAIL_FLAG_EN]
		&& selftest_fail_flag_in)
		|| (error_interrupt_control[`VMC_FLD_HWFAULT_EN]
		&& hw_fault_flag_in)
		|| (error_interrupt_control[`VMC_FLD_BUSFAULT_EN]
		&& flags[0]);

	assign error_irq_level = error_interrupt_control[`VMC_FLD_LEVEL_HI:0];
	assign irq_pending = error_pending || reg_pending_flag;

	// Level zero never requests, so it also can never be acknowledged.
	assign iack_match = iack_in && irq_pending
		&& (error_irq_level != 3'h0)
		&& (iack_level_in == error_irq_level);

	always_comb
	begin
		next_request = 7'h00;
		if (irq_pending && error_irq_level != 3'h0)
			next_request[error_irq_level] = 1'b1;
	end

	// The request drops on the same edge that takes an acknowledge so the taken event
	// cannot be answered twice while its flag is clearing.
	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			irq_request_out <= 7'h00;
		end
		else if (iack_match)
		begin
			irq_request_out <= 7'h00;
		end
		else
		begin
			irq_request_out <= next_request;
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			iack_ack_out    <= 1'b0;
			iack_vector_out <= 8'h00;
		end
		else
		begin
			iack_ack_out <= iack_match;
			if (iack_match)
				iack_vector_out <= error_interrupt_vector;
		end
	end

endmodule

// *** hw/vmc_cfg.svh ***
// Offsets, field positions, reset values and fixed codes of the bank.
// Assumes byte-wide register access on the board's short I/O decode.
`ifndef VMC_CFG_SVH
`define VMC_CFG_SVH

`define VMC_OFS_SIZE_MOD       8'h10
`define VMC_OFS_TEST_SEL       8'h11
`define VMC_OFS_ERR_CTRL       8'h12
`define VMC_OFS_ERR_VEC        8'h13
`define VMC_OFS_BASE_B3        8'h14
`define VMC_OFS_BASE_B2        8'h15
`define VMC_OFS_BASE_B1        8'h16
`define VMC_OFS_BASE_B0        8'h17

`define VMC_RST_SIZE_MOD       8'hB9
`define VMC_RST_TEST_SEL       8'h00
`define VMC_RST_ERR_CTRL       8'h00
`define VMC_RST_ERR_VEC        8'h00
`define VMC_RST_BASE           32'h0000_0000
`define VMC_UNMAPPED_DATA      8'h00

`define VMC_FLD_WIDTH_HI       7
`define VMC_FLD_WIDTH_LO       6
`define VMC_FLD_AM_HI          5
`define VMC_FLD_TEST_HI        5
`define VMC_FLD_TEST_RSV_HI    7
`define VMC_FLD_TEST_RSV_LO    6
`define VMC_FLD_SETTLED_EN     7
`define VMC_FLD_RSV_EN         6
`define VMC_FLD_SELFTEST_FAIL_FLAG_EN      5
`define VMC_FLD_HWFAULT_EN     4
`define VMC_FLD_BUSFAULT_EN    3
`define VMC_FLD_LEVEL_HI       2

`define VMC_CODE_WORD          2'b00
`define VMC_CODE_HALF          2'b10
`define VMC_CODE_BYTE          2'b01
`define VMC_AM_A24_TAG         2'b11
`define VMC_AM_A32_TAG         2'b00

`endif

// *** hw/vmc_pkg.sv ***
// Types and shared decoding of the master configuration bank.
// Assumes vmc_cfg.svh sits on the include path.
`include "vmc_cfg.svh"

package vmc_pkg;

	typedef enum logic [1:0] {
		VMC_WIDTH_WORD,
		VMC_WIDTH_HALF,
		VMC_WIDTH_BYTE,
		VMC_WIDTH_UNDEF
	} vmc_width_t;

	// Standard A24 addressing modifiers carry ones in their top two bits, A32 modifiers zeros.
	function automatic logic vmc_is_a24(input logic [5:0] am);
		vmc_is_a24 = (am[5:4] == `VMC_AM_A24_TAG);
	endfunction

	function automatic logic vmc_is_a32(input logic [5:0] am);
		vmc_is_a32 = (am[5:4] == `VMC_AM_A32_TAG);
	endfunction

endpackage

// *** hw/vmc_sticky_flag.sv ***
// A row of sticky event flags, each set by a pulse and cleared by a pulse.
// Assumes set and clear pulses are synchronous to clk_in.
module vmc_sticky_flag #(
	parameter int WIDTH = 2
) (
	input  wire logic             clk_in,
	input  wire logic             rst_b_in,
	input  wire logic [WIDTH-1:0] set_in,
	input  wire logic [WIDTH-1:0] clear_in,
	output logic      [WIDTH-1:0] flag_out
);

	// A set arriving with a clear wins, so no event is ever dropped.
	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			flag_out <= '0;
		end
		else
		begin
			flag_out <= set_in | (flag_out & ~clear_in);
		end
	end

endmodule

// *** hw/vmc_addr_unit.sv ***
// Master address generation and slave window decode from the buffer base.
// Assumes requests are single-cycle strobes on clk_in.
`include "vmc_cfg.svh"

module vmc_addr_unit #(
	parameter int ALIGN_BITS = 18
) (
	input  wire logic        clk_in,
	input  wire logic        rst_b_in,
	input  wire logic [31:0] base_in,
	input  wire logic [5:0]  master_am_in,
	input  wire logic        master_req_in,
	input  wire logic [31:0] master_offset_in,
	input  wire logic        wide_decode_in,
	input  wire logic        slave_valid_in,
	input  wire logic [31:0] slave_addr_in,
	input  wire logic [5:0]  slave_am_in,
	output logic             master_start_out,
	output logic      [31:0] master_addr_out,
	output logic             slave_hit_out,
	output logic      [31:0] slave_offset_out
);

	logic [31:0] sum;
	logic [31:0] window_mask;
	logic        space_ok;
	logic [31:0] addr_view;
	logic [31:0] base_view;

	assign sum = base_in + master_offset_in;
	assign window_mask = ~((32'h0000_0001 << ALIGN_BITS) - 32'h0000_0001);

	// A24 cycles look only at the low 24 bits of both sides.
	assign space_ok = wide_decode_in ? vmc_pkg::vmc_is_a32(slave_am_in)
		: vmc_pkg::vmc_is_a24(slave_am_in);
	assign addr_view = wide_decode_in ? slave_addr_in
		: {8'h00, slave_addr_in[23:0]};
	assign base_view = wide_decode_in ? base_in : {8'h00, base_in[23:0]};

	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			master_start_out <= 1'b0;
			master_addr_out  <= 32'h0000_0000;
		end
		else
		begin
			master_start_out <= master_req_in;
			if (master_req_in)
			begin
				if (vmc_pkg::vmc_is_a24(master_am_in))
					master_addr_out <= {8'h00, sum[23:0]};
				else
					master_addr_out <= sum;
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			slave_hit_out    <= 1'b0;
			slave_offset_out <= 32'h0000_0000;
		end
		else
		begin
			slave_hit_out <= slave_valid_in && space_ok
				&& ((addr_view & window_mask)
				== (base_view & window_mask));
			slave_offset_out <= addr_view & ~window_mask;
		end
	end

endmodule

// *** sim/vmc_config_monitor.sv ***
// Port assertions for the master configuration bank.
// Assumes byte register writes and one clock; bound to the bank below.
module vmc_config_monitor #(
	parameter int ALIGN_BITS = 18
) (
	input  wire logic        clk_in,
	input  wire logic        rst_b_in,
	input  wire logic [7:0]  reg_addr_in,
	input  wire logic        reg_wr_in,
	input  wire logic [7:0]  reg_wdata_in,
	input  wire logic        self_test_start_bit_in,
	input  wire logic        slave_wide_decode_in,
	input  wire logic        reg_settled_in,
	input  wire logic        hw_fault_flag_in,
	input  wire logic        master_bus_error_in,
	input  wire logic        iack_in,
	input  wire logic [2:0]  iack_level_in,
	input  wire logic        iack_ack_out,
	input  wire logic [7:0]  iack_vector_out,
	input  wire logic [7:1]  irq_request_out,
	input  wire logic        master_req_in,
	input  wire logic [31:0] master_offset_in,
	input  wire logic        master_start_out,
	input  wire logic [31:0] master_addr_out,
	input  wire logic [5:0]  master_modifier_field_out,
	input  vmc_pkg::vmc_width_t master_width_code_out,
	input  wire logic        slave_valid_in,
	input  wire logic [31:0] slave_addr_in,
	input  wire logic [5:0]  slave_am_in,
	input  wire logic        slave_hit_out,
	input  wire logic [5:0]  self_test_run_out,
	input  wire logic        bus_fault_flag_out,
	input  wire logic        reserved_nonzero_flag_out
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0]          size_q, sel_q, ctl_q, vec_q, irq8;
	logic [31:0]         base_q, sum, mask, exp_addr, dif;
	logic [2:0]          lvl;
	logic                hit_exp;
	vmc_pkg::vmc_width_t exp_w;

	// Shadow copies of the bank, so expectations never read the design.
	always_ff @(posedge clk_in or negedge rst_b_in)
		if (!rst_b_in)
		begin
			size_q <= 8'hB9;
			{sel_q, ctl_q, vec_q, base_q} <= 56'h0;
		end
		else if (reg_wr_in)
			case (reg_addr_in)
				8'h10: size_q <= reg_wdata_in;
				8'h11: sel_q <= reg_wdata_in;
				8'h12: ctl_q <= reg_wdata_in;
				8'h13: vec_q <= reg_wdata_in;
				8'h14: base_q[31:24] <= reg_wdata_in;
				8'h15: base_q[23:16] <= reg_wdata_in;
				8'h16: base_q[15:8] <= reg_wdata_in;
				8'h17: base_q[7:0] <= reg_wdata_in;
				default: ;
			endcase

	always_comb
		case (size_q[7:6])
			2'b00: exp_w = vmc_pkg::VMC_WIDTH_WORD;
			2'b10: exp_w = vmc_pkg::VMC_WIDTH_HALF;
			2'b01: exp_w = vmc_pkg::VMC_WIDTH_BYTE;
			default: exp_w = vmc_pkg::VMC_WIDTH_UNDEF;
		endcase

	assign irq8 = {irq_request_out, 1'b0};
	assign lvl = ctl_q[2:0];
	assign sum = base_q + master_offset_in;
	assign exp_addr = (size_q[5:4] == 2'b11) ? {8'h00, sum[23:0]} : sum;
	assign mask = ~((32'h1 << ALIGN_BITS) - 32'h1);
	assign dif = (slave_addr_in ^ base_q) & mask;
	assign hit_exp = slave_valid_in && (slave_wide_decode_in
		? (slave_am_in[5:4] == 2'b00 && dif == 32'h0)
		: (slave_am_in[5:4] == 2'b11 && dif[23:0] == 24'h0));

	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);

	////////////////////////////////////////////////////////////////////////
	a_size_outputs: assert property (
		$stable(size_q) |-> master_modifier_field_out == size_q[5:0]
		&& master_width_code_out == exp_w) else $error("size outputs off");
	a_test_run: assert property (
		self_test_start_bit_in |=> {2'b00, self_test_run_out}
		== ($past(sel_q) & 8'h3F)) else $error("wrong tests run");
	a_test_idle: assert property (
		!self_test_start_bit_in |=> self_test_run_out == 6'h00)
		else $error("tests run unasked");
	a_settled_irq: assert property (
		reg_settled_in && !iack_in && ctl_q[7] && lvl != 3'h0 ##1 !iack_in
		|-> ##1 irq8[lvl]) else $error("settled request missing");
	a_bus_irq: assert property (
		master_bus_error_in && !iack_in && ctl_q[3] && lvl != 3'h0
		##1 !iack_in |-> ##1 irq8[lvl]) else $error("bus request missing");
	a_hw_irq: assert property (
		hw_fault_flag_in && ctl_q[4] && lvl != 3'h0 && !iack_in
		&& !$past(iack_in) && !reg_wr_in |=> irq8[lvl])
		else $error("fault request missing");
	a_level_zero: assert property (
		(lvl == 3'h0 && $past(lvl) == 3'h0) ? irq_request_out == 7'h00
		: $onehot0(irq_request_out)) else $error("bad request level");
	a_vector_ack: assert property (
		iack_in && iack_level_in != 3'h0 && irq8[iack_level_in]
		|=> iack_ack_out && iack_vector_out == vec_q)
		else $error("ack or vector missing");
	a_bus_flag: assert property (
		master_bus_error_in |-> ##2 bus_fault_flag_out)
		else $error("bus fault flag not set");
	a_master_addr: assert property (
		master_req_in |=> master_start_out
		&& master_addr_out == $past(exp_addr)) else $error("master addr");
	a_slave_decode: assert property (
		1'b1 |=> slave_hit_out == $past(hit_exp)) else $error("slave hit");
	a_reserved_flag: assert property (
		(sel_q & 8'hC0) != 8'h00 && ($past(sel_q) & 8'hC0) != 8'h00
		|-> reserved_nonzero_flag_out) else $error("reserved flag");

	c_ack: cover property (iack_ack_out);
	c_start: cover property (master_start_out);
	c_hit: cover property (slave_hit_out);
endmodule

bind vmc_config_bank vmc_config_monitor #(.ALIGN_BITS(ALIGN_BITS)) u_mon (.*);

// *** sim/vmc_host_model.sv ***
// Host side model: answers interrupt requests with acknowledge cycles.
// Assumes the bank's request lines are registered on clk_in.
module vmc_host_model (
	input  wire logic       clk_in,
	input  wire logic       enable_in,
	input  wire logic       wrong_in,
	input  wire logic [3:0] delay_in,
	input  wire logic [7:1] irq_in,
	input  wire logic       ack_in,
	input  wire logic [7:0] vector_in,
	output logic            iack_out,
	output logic      [2:0] level_out,
	output logic      [7:0] vec_out,
	output int              acks_out
);
	timeunit 1ns;
	timeprecision 1ps;

	initial
	begin
		iack_out = 1'b0;
		level_out = 3'h0;
		vec_out = 8'h00;
		acks_out = 0;
		forever
		begin
			@(negedge clk_in);
			if (enable_in && irq_in != 7'h00)
			begin
				repeat (delay_in) @(negedge clk_in);
				for (int i = 1; i < 8; i++)
					if (irq_in[i])
						level_out = 3'(i) + {2'b00, wrong_in};
				iack_out = 1'b1;
				@(negedge clk_in);
				if (ack_in === 1'b1)
				begin
					vec_out = vector_in;
					acks_out++;
				end
				iack_out = 1'b0;
				// A released level line shows the inverse, not the old value.
				level_out = ~level_out;
			end
		end
	end
endmodule

// *** sim/test_vmc_config_bank.sv ***
// Self-checking bench for the configuration bank with a host model.
// Assumes the bank, its package and the monitor are compiled first.
module test_vmc_config_bank;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk_in = 1'b0;
	logic rst_b_in, reg_wr_in, reg_rd_in, reg_ack_out, iack_in, iack_ack_out;
	logic self_test_start_bit_in, slave_wide_decode_in, reg_settled_in;
	logic selftest_fail_flag_in, hw_fault_flag_in, master_bus_error_in;
	logic bus_fault_clear_in, reserved_other_in, master_req_in;
	logic master_start_out, slave_valid_in, slave_hit_out, any_error_out;
	logic bus_fault_flag_out, reserved_nonzero_flag_out, h_en, h_wrong;
	logic [7:0]  reg_addr_in, reg_wdata_in, reg_rdata_out, iack_vector_out;
	logic [7:0]  h_vec;
	logic [3:0]  h_delay;
	logic [2:0]  iack_level_in;
	logic [7:1]  irq_request_out;
	logic [5:0]  master_modifier_field_out, slave_am_in, self_test_run_out;
	logic [31:0] master_offset_in, master_addr_out, slave_addr_in;
	logic [31:0] slave_offset_out;
	vmc_pkg::vmc_width_t master_width_code_out;
	int          h_acks, fail_count = 0, checked = 0, n;

	vmc_config_bank u_dut (.*);
	vmc_host_model u_host (.clk_in(clk_in), .enable_in(h_en),
		.wrong_in(h_wrong), .delay_in(h_delay), .irq_in(irq_request_out),
		.ack_in(iack_ack_out), .vector_in(iack_vector_out),
		.iack_out(iack_in), .level_out(iack_level_in), .vec_out(h_vec),
		.acks_out(h_acks));

	always #2.5 clk_in = ~clk_in;

	////////////////////////////////////////////////////////////////////////
	task chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e)
		begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_in);
		reg_addr_in = a;
		reg_wdata_in = d;
		reg_wr_in = 1'b1;
		@(negedge clk_in);
		reg_wr_in = 1'b0;
	endtask

	task rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk_in);
		reg_addr_in = a;
		reg_rd_in = 1'b1;
		@(negedge clk_in);
		reg_rd_in = 1'b0;
		chk(reg_ack_out, 1);
		chk(reg_rdata_out, e);
	endtask

	task end_sim;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	task t_reset;
		rd(8'h10, 8'hB9);
		for (int i = 8'h11; i < 8'h19; i++)
			rd(8'(i), 8'h00);
		chk(master_modifier_field_out, 8'h39);
		chk(master_width_code_out, vmc_pkg::VMC_WIDTH_HALF);
		$display("test reset done");
	endtask

	task t_size;
		logic [7:0] v [4];
		vmc_pkg::vmc_width_t w [4];
		v = '{8'h09, 8'hB9, 8'h69, 8'hED};
		w = '{vmc_pkg::VMC_WIDTH_WORD, vmc_pkg::VMC_WIDTH_HALF,
			vmc_pkg::VMC_WIDTH_BYTE, vmc_pkg::VMC_WIDTH_UNDEF};
		for (int i = 0; i < 4; i++)
		begin
			wr(8'h10, v[i]);
			@(negedge clk_in);
			chk(master_modifier_field_out, v[i] & 8'h3F);
			chk(master_width_code_out, w[i]);
			rd(8'h10, v[i]);
		end
		$display("test size done");
	endtask

	task t_test;
		for (int i = 0; i < 7; i++)
		begin
			wr(8'h11, (i < 6) ? 8'h01 << i : 8'hEA);
			@(negedge clk_in);
			self_test_start_bit_in = 1'b1;
			@(negedge clk_in);
			self_test_start_bit_in = 1'b0;
			chk(self_test_run_out, (i < 6) ? 8'h01 << i : 8'h2A);
		end
		chk(reserved_nonzero_flag_out, 1);
		rd(8'h11, 8'hEA);
		wr(8'h11, 8'h00);
		@(negedge clk_in);
		chk(reserved_nonzero_flag_out, 0);
		$display("test self test done");
	endtask

	task t_master;
		for (int i = 0; i < 4; i++)
			wr(8'(8'h14 + i), 8'(32'h1234_0000 >> (24 - 8 * i)));
		rd(8'h14, 8'h12);
		for (int i = 0; i < 2; i++)
		begin
			wr(8'h10, i ? 8'hB9 : 8'h09);
			@(negedge clk_in);
			master_offset_in = 32'h00FF_0010;
			master_req_in = 1'b1;
			@(negedge clk_in);
			master_req_in = 1'b0;
			chk(master_start_out, 1);
			chk(master_addr_out, i ? 32'h0033_0010 : 32'h1333_0010);
		end
		$display("test master done");
	endtask

	// The base set above is a multiple of the smallest slave window.
	task t_slave;
		logic [31:0] ad [4];
		ad = '{32'h0034_0010, 32'h0034_0010, 32'h1237_FFFF, 32'h1238_0000};
		for (int i = 0; i < 4; i++)
		begin
			@(negedge clk_in);
			slave_wide_decode_in = (i >= 2);
			slave_am_in = (i == 0) ? 6'h39 : 6'h09;
			slave_addr_in = ad[i];
			slave_valid_in = 1'b1;
			@(negedge clk_in);
			slave_valid_in = 1'b0;
			slave_addr_in = ~ad[i];
			chk(slave_hit_out, (i % 2) == 0);
			if (i % 2 == 0)
				chk(slave_offset_out, ad[i] & 32'h0003_FFFF);
		end
		$display("test slave done");
	endtask

	task t_irq;
		wr(8'h13, 8'h5A);
		wr(8'h12, 8'h83);
		h_en = 1'b1;
		for (int k = 0; k < 2; k++)
		begin
			@(negedge clk_in);
			{master_bus_error_in, reg_settled_in} = k ? 2'b10 : 2'b01;
			@(negedge clk_in);
			{master_bus_error_in, reg_settled_in} = 2'b00;
			repeat (12) @(negedge clk_in);
			chk(h_acks > k, 1);
			chk(h_vec, 8'h5A);
			chk(irq_request_out, k ? 7'h10 : 7'h00);
			if (k == 0)
				wr(8'h12, 8'h0D);
			h_delay = 4'h3;
		end
		chk(bus_fault_flag_out, 1);
		h_en = 1'b0;
		repeat (6) @(negedge clk_in);
		bus_fault_clear_in = 1'b1;
		@(negedge clk_in);
		bus_fault_clear_in = 1'b0;
		repeat (3) @(negedge clk_in);
		chk({bus_fault_flag_out, irq_request_out}, 8'h00);
		$display("test interrupt done");
	endtask

	task t_mask;
		logic [19:0] t [6];
		t = '{20'h03400, 20'h13404, 20'h10400, 20'h25210, 20'h47140,
			20'h07100};
		for (int i = 0; i < 6; i++)
		begin
			wr(8'h12, t[i][19:12]);
			{hw_fault_flag_in, selftest_fail_flag_in, reserved_other_in} =
				t[i][10:8];
			repeat (3) @(negedge clk_in);
			chk(irq_request_out, t[i][6:0]);
			chk(any_error_out, 1);
			if (i == 1)
			begin
				n = h_acks;
				{h_en, h_wrong, h_delay} = 6'h30;
				repeat (8) @(negedge clk_in);
				h_en = 1'b0;
				repeat (4) @(negedge clk_in);
				chk(h_acks, n);
			end
			{hw_fault_flag_in, selftest_fail_flag_in, reserved_other_in} = 0;
			repeat (3) @(negedge clk_in);
		end
		$display("test masks done");
	endtask

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		{rst_b_in, reg_wr_in, reg_rd_in, self_test_start_bit_in,
			slave_wide_decode_in, reg_settled_in, selftest_fail_flag_in,
			hw_fault_flag_in, master_bus_error_in, bus_fault_clear_in,
			reserved_other_in, master_req_in, slave_valid_in, h_en,
			h_wrong, h_delay} = '0;
		{reg_addr_in, reg_wdata_in, slave_am_in} = '0;
		{master_offset_in, slave_addr_in} = '0;
		repeat (10) @(negedge clk_in);
		rst_b_in = 1'b1;
		t_reset;
		t_size;
		t_test;
		t_master;
		t_slave;
		t_irq;
		t_mask;
		end_sim;
	end

	// The sequence needs well under two thousand cycles.
	initial
	begin
		#50000;
		fail_count++;
		end_sim;
	end
endmodule
